// ===== wic_defines.vh
`ifndef WIC_DEFINES_VH
`define WIC_DEFINES_VH

// Register addresses
`define WIC_ADDR_P1_WAKE 8'hC0
`define WIC_ADDR_IRQ_FLAGS 8'hC8
`define WIC_ADDR_IRQ_EN 8'hC9
`define WIC_ADDR_MODE 8'hCA
`define WIC_ADDR_STACK 8'hDF

// Field positions
`define WIC_BIT_EXT 0
`define WIC_BIT_TA 4
`define WIC_BIT_TB 5
`define WIC_BIT_GIE 7
`define WIC_BIT_PDOWN 0
`define WIC_BIT_IDLE 1
`define WIC_BIT_SLOW 2

// Implemented bits per register
`define WIC_MASK_P1_WAKE 8'h7F
`define WIC_MASK_IRQ 8'h31
`define WIC_MASK_MODE 8'h07

// Reset values
`define WIC_RST_P1_WAKE 8'h00
`define WIC_RST_IRQ_FLAGS 8'h00
`define WIC_RST_IRQ_EN 8'h00
`define WIC_RST_MODE 8'h00
`define WIC_RST_GIE 1'b0
`define WIC_RST_VECTOR 12'h000

// Interrupt vector
`define WIC_VECTOR 12'h008

// Oscillator settling after power-down wake, in oscillator clocks
`define WIC_WAKE_CLOCKS 6'h20

// Edges after reset release before a pin difference may count as a change
`define WIC_ARM_CYCLES 3'h4

`endif

// ===== wic_ctrl.v
// What this block does
// - Power-down wakes only on port 0/1 level change, always back to normal mode.
// - Green mode wakes on pin change or timer A overflow, back to prior mode.
// - Power-down wake waits 32 oscillator clocks before entering normal mode.
// - Green mode wake has no settling delay.
// - Both rising and falling edges on an enabled pin wake the system.
// - Port 0 pins always wake; port 1 pins wake only when enabled.
// - Port 1 wake enable at C0, bits 0-6, write-only, reset 0.
// - Three interrupt sources: timer A, timer B, external pin on port 0 bit 0.
// - External pin interrupt also wakes power-down into normal mode.
// - Entering interrupt service clears the global interrupt enable.
// - Return from interrupt sets the global interrupt enable again.
// - Taking an interrupt pushes return address and loads vector 8.
// - Enable register at C9: bit 0 pin, bit 4 timer A, bit 5 timer B.
// - Request register at C8: same bits, set on request, reset 0.
// - Request flags stay set until software clears them by writing.
// - Global enable is bit 7 at DF, read/write, reset 0, blocks interrupts.
// - Flags set on trigger regardless of enable; only enabled ones vector.
// - Power-down and idle request bits self-clear on resumption.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "wic_defines.vh"

module wic_ctrl (
    input wire clk,
    input wire rstn,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire [7:0] port0_pins,
    input wire [6:0] port1_pins,
    input wire timer_a_ovf,
    input wire timer_b_ovf,
    input wire instr_boundary,
    input wire return_from_interrupt,
    output wire core_halt,
    output wire osc_stop,
    output wire slow_mode,
    output wire irq_level,
    output reg irq_take,
    output wire stack_push,
    output reg [11:0] vector_pc,
    output wire global_irq_enable
);

    localparam [1:0] ST_RUN = 2'b00;
    localparam [1:0] ST_PDOWN = 2'b01;
    localparam [1:0] ST_WARM = 2'b10;
    localparam [1:0] ST_GREEN = 2'b11;
    localparam NPIN = 15;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [5:0] warm_cnt_q;
    reg [5:0] warm_cnt_d;
    reg [7:0] port1_wake_enable_q;
    reg [7:0] irq_flags_q;
    reg [7:0] irq_flags_d;
    reg [7:0] irq_enable_q;
    reg [7:0] mode_q;
    reg [7:0] mode_d;
    reg gie_q;
    reg gie_d;
    reg take_d;
    reg [7:0] rdata_d;
    reg halt_q;
    reg osc_stop_q;

    wire [NPIN-1:0] pin_raw;
    wire [NPIN-1:0] pin_wake_en;
    wire [NPIN-1:0] pin_change;
    wire pin_wake;
    wire ext_pin_event;
    wire [7:0] irq_events;
    wire [7:0] irq_active;
    wire wr_p1w;
    wire wr_flags;
    wire wr_en;
    wire wr_mode;
    wire wr_stack;

    assign pin_raw = {port1_pins, port0_pins};
    assign pin_wake_en = {port1_wake_enable_q[6:0], 8'hFF};

    // Three-stage sync; a change counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin
            reg s1_q;
            reg s2_q;
            reg s3_q;
            reg level_q;
            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    level_q <= 1'b0;
                end else begin
                    s1_q <= pin_raw[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        level_q <= s3_q;
                    end
                end
            end
            // Either direction counts as a change
            assign pin_change[gi] = (s2_q == s3_q) && (s3_q != level_q);
        end
    endgenerate

    // A pin already high at reset takes four edges to settle, so stay blind that long
    reg [2:0] arm_q;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            arm_q <= 3'h0;
        end else if (arm_q != `WIC_ARM_CYCLES) begin
            arm_q <= arm_q + 3'h1;
        end
    end

    assign pin_wake = (arm_q == `WIC_ARM_CYCLES) && (|(pin_change & pin_wake_en));
    assign ext_pin_event = (arm_q == `WIC_ARM_CYCLES) && pin_change[0];

    // Register bus decode
    assign wr_p1w = reg_wr && (reg_addr == `WIC_ADDR_P1_WAKE);
    assign wr_flags = reg_wr && (reg_addr == `WIC_ADDR_IRQ_FLAGS);
    assign wr_en = reg_wr && (reg_addr == `WIC_ADDR_IRQ_EN);
    assign wr_mode = reg_wr && (reg_addr == `WIC_ADDR_MODE);
    assign wr_stack = reg_wr && (reg_addr == `WIC_ADDR_STACK);

    // Interrupt sources
    assign irq_events[`WIC_BIT_EXT] = ext_pin_event;
    assign irq_events[3:1] = 3'b000;
    assign irq_events[`WIC_BIT_TA] = timer_a_ovf;
    assign irq_events[`WIC_BIT_TB] = timer_b_ovf;
    assign irq_events[7:6] = 2'b00;

    assign irq_active = irq_flags_q & irq_enable_q;
    assign irq_level = |irq_active;

    // Request flags: software write replaces, a same-cycle event still sets
    always @* begin
        irq_flags_d = irq_flags_q;
        if (wr_flags) begin
            irq_flags_d = reg_wdata & `WIC_MASK_IRQ;
        end
        irq_flags_d = irq_flags_d | irq_events;
    end

    // Take only at a boundary while running; several pending share one entry
    always @* begin
        take_d = 1'b0;
        if ((state_q == ST_RUN) && instr_boundary && gie_q && irq_level) begin
            take_d = 1'b1;
        end
    end

    // Global enable; hardware take wins over a same-cycle software write
    always @* begin
        gie_d = gie_q;
        if (wr_stack) begin
            gie_d = reg_wdata[`WIC_BIT_GIE];
        end
        if (return_from_interrupt) begin
            gie_d = 1'b1;
        end
        if (take_d) begin
            gie_d = 1'b0;
        end
    end

    // Operating mode sequencer
    always @* begin
        state_d = state_q;
        warm_cnt_d = warm_cnt_q;
        mode_d = mode_q;
        case (state_q)
            ST_RUN: begin
                if (wr_mode) begin
                    mode_d = reg_wdata & `WIC_MASK_MODE;
                    if (reg_wdata[`WIC_BIT_PDOWN]) begin
                        state_d = ST_PDOWN;
                    end else if (reg_wdata[`WIC_BIT_IDLE]) begin
                        state_d = ST_GREEN;
                    end
                end
            end
            ST_PDOWN: begin
                // Timers are ignored here: only pins can wake
                if (pin_wake) begin
                    state_d = ST_WARM;
                    warm_cnt_d = 6'h00;
                end
            end
            ST_WARM: begin
                // Oscillator settling before code runs again
                warm_cnt_d = warm_cnt_q + 6'h01;
                if (warm_cnt_q == (`WIC_WAKE_CLOCKS - 6'h01)) begin
                    state_d = ST_RUN;
                    mode_d[`WIC_BIT_PDOWN] = 1'b0;
                    mode_d[`WIC_BIT_IDLE] = 1'b0;
                    mode_d[`WIC_BIT_SLOW] = 1'b0;
                    warm_cnt_d = 6'h00;
                end
            end
            ST_GREEN: begin
                // Clock keeps running, so resume at once in the prior speed
                if (pin_wake || timer_a_ovf) begin
                    state_d = ST_RUN;
                    mode_d[`WIC_BIT_IDLE] = 1'b0;
                end
            end
            default: begin
                state_d = ST_RUN;
                warm_cnt_d = 6'h00;
            end
        endcase
    end

    // Read mux; wake enable is write-only and reads zero
    always @* begin
        rdata_d = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `WIC_ADDR_IRQ_FLAGS: begin
                    rdata_d = irq_flags_q;
                end
                `WIC_ADDR_IRQ_EN: begin
                    rdata_d = irq_enable_q;
                end
                `WIC_ADDR_MODE: begin
                    rdata_d = mode_q;
                end
                `WIC_ADDR_STACK: begin
                    rdata_d = {gie_q, 7'h00};
                end
                default: begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            port1_wake_enable_q <= `WIC_RST_P1_WAKE;
        end else if (wr_p1w) begin
            port1_wake_enable_q <= reg_wdata & `WIC_MASK_P1_WAKE;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_enable_q <= `WIC_RST_IRQ_EN;
        end else if (wr_en) begin
            irq_enable_q <= reg_wdata & `WIC_MASK_IRQ;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_flags_q <= `WIC_RST_IRQ_FLAGS;
        end else begin
            irq_flags_q <= irq_flags_d;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gie_q <= `WIC_RST_GIE;
        end else begin
            gie_q <= gie_d;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            warm_cnt_q <= 6'h00;
        end else begin
            warm_cnt_q <= warm_cnt_d;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= `WIC_RST_MODE;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Status pins come from flops so the core never sees decode glitches
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            halt_q <= 1'b0;
            osc_stop_q <= 1'b0;
        end else begin
            halt_q <= (state_d != ST_RUN);
            osc_stop_q <= (state_d == ST_PDOWN);
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_take <= 1'b0;
        end else begin
            irq_take <= take_d;
        end
    end

    // Vector holds after entry so a slow fetch still finds it
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            vector_pc <= `WIC_RST_VECTOR;
        end else if (take_d) begin
            vector_pc <= `WIC_VECTOR;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= rdata_d;
        end
    end

    // Core pushes the return address when this pulse arrives
    assign stack_push = irq_take;
    assign core_halt = halt_q;
    assign osc_stop = osc_stop_q;
    assign slow_mode = mode_q[`WIC_BIT_SLOW];
    assign global_irq_enable = gie_q;

endmodule

// ===== wic_ctrl_monitor.sv
`timescale 1ns/1ps
module wic_ctrl_monitor (
    input wire clk,
    input wire rstn,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_rdata,
    input wire instr_boundary,
    input wire return_from_interrupt,
    input wire core_halt,
    input wire osc_stop,
    input wire irq_level,
    input wire irq_take,
    input wire stack_push,
    input wire [11:0] vector_pc,
    input wire global_irq_enable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // Core is halted for the first 8 settling clocks and again at the 32nd, then runs
    sequence s_warm;
        core_halt [*8] ##24 core_halt ##1 !core_halt;
    endsequence
    chk_warm_delay: assert property ($fell(osc_stop) |-> s_warm)
        else $error("warmup length wrong");
    chk_pd_halted: assert property (osc_stop |-> core_halt)
        else $error("oscillator stopped while running");
    chk_entry_vec: assert property (irq_take |-> !global_irq_enable && stack_push && vector_pc == 12'h008)
        else $error("entry without vector or push");
    chk_rfi_gie: assert property (return_from_interrupt && !global_irq_enable |=> global_irq_enable)
        else $error("return did not enable");
    chk_gie_gate: assert property (!global_irq_enable |=> !irq_take)
        else $error("entry while disabled");
    chk_take_cause: assert property (irq_take |-> $past(instr_boundary && irq_level && !core_halt))
        else $error("entry without cause");
    chk_take_once: assert property (irq_take |=> !irq_take)
        else $error("entry repeated");
    chk_wo_read: assert property (reg_rd && reg_addr == 8'hC0 |=> reg_rdata == 8'h00)
        else $error("write-only register readable");
endmodule
bind wic_ctrl wic_ctrl_monitor u_mon (.*);

// ===== wic_core_model.sv
`timescale 1ns/1ps
module wic_core_model (
    input wire clk,
    input wire rstn,
    input wire irq_take,
    output reg instr_boundary,
    output reg return_from_interrupt
);
    reg [4:0] step_q;
    reg busy_q;
    // Uneven boundaries so entry meets both prompt and slow instructions
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            step_q <= 5'h00;
            busy_q <= 1'b0;
            instr_boundary <= 1'b0;
            return_from_interrupt <= 1'b0;
        end else begin
            step_q <= step_q + 5'h01;
            instr_boundary <= step_q[0] | step_q[3];
            return_from_interrupt <= busy_q && step_q == 5'h1F;
            if (irq_take) begin
                busy_q <= 1'b1;
                step_q <= 5'h00;
            end else if (return_from_interrupt) begin
                busy_q <= 1'b0;
            end
        end
    end
endmodule

// ===== wic_ctrl_bench.sv
`timescale 1ns/1ps
module wic_ctrl_bench;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg [7:0] reg_addr = 8'h00;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [7:0] port0_pins = 8'h00;
    reg [6:0] port1_pins = 7'h00;
    reg timer_a_ovf = 1'b0;
    reg timer_b_ovf = 1'b0;
    wire [7:0] reg_rdata;
    wire [11:0] vector_pc;
    wire instr_boundary, return_from_interrupt, core_halt, osc_stop, slow_mode;
    wire irq_level, irq_take, stack_push, global_irq_enable;
    integer n_mismatch = 0;
    integer checks_done = 0;
    integer seed = 13;
    integer i;
    integer r;
    reg [7:0] expf = 8'h00;
    wic_ctrl DUT (.*);
    wic_core_model core (.clk(clk), .rstn(rstn), .irq_take(irq_take), .instr_boundary(instr_boundary),
        .return_from_interrupt(return_from_interrupt));
    initial forever #4 clk = ~clk;
    initial begin
        #40000;
        n_mismatch = n_mismatch + 1;
        conclude;
    end
    function [7:0] tmr_flags(input [7:0] v);
        tmr_flags = {2'b00, v[1], v[0], 4'h0};
    endfunction
    task cmp(input [11:0] got, input [11:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // Each access ends with a low strobe edge so calls never collide
    task acc(input w, input [7:0] a, input [7:0] d);
        begin
            @(posedge clk);
            reg_wr <= w;
            reg_rd <= !w;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge clk);
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            #1 if (!w) cmp({4'h0, reg_rdata}, {4'h0, d});
        end
    endtask
    task pulse_ta;
        begin
            @(posedge clk);
            timer_a_ovf <= 1'b1;
            @(posedge clk);
            timer_a_ovf <= 1'b0;
        end
    endtask
    task wait_run;
        for (i = 0; i < 60 && core_halt !== 1'b0; i = i + 1) @(posedge clk) #1;
    endtask
    task conclude;
        begin
            $display("mismatches %0d checks %0d", n_mismatch, checks_done);
            if (n_mismatch == 0 && checks_done > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        acc(0, 8'hC8, 8'h00);
        acc(0, 8'hC9, 8'h00);
        acc(0, 8'hDF, 8'h00);
        acc(1, 8'hC0, 8'h01);
        acc(0, 8'hC0, 8'h00);
        acc(0, 8'h55, 8'h00);
        acc(1, 8'hC9, 8'hFF);
        acc(0, 8'hC9, 8'h31);
        acc(1, 8'hC9, 8'h00);
        for (i = 0; i < 8; i = i + 1) begin
            r = $random(seed);
            @(posedge clk);
            timer_a_ovf <= r[0];
            timer_b_ovf <= r[1];
            expf = expf | tmr_flags(r[7:0]);
            @(posedge clk);
            timer_a_ovf <= 1'b0;
            timer_b_ovf <= 1'b0;
        end
        acc(0, 8'hC8, expf);
        cmp({11'h000, irq_level}, 12'h000);
        acc(1, 8'hC8, 8'h00);
        acc(0, 8'hC8, 8'h00);
        acc(1, 8'hC9, 8'h10);
        acc(1, 8'hDF, 8'h80);
        acc(0, 8'hDF, 8'h80);
        pulse_ta;
        for (i = 0; i < 40 && irq_take !== 1'b1; i = i + 1) @(posedge clk) #1;
        cmp({11'h000, irq_take}, 12'h001);
        cmp({11'h000, stack_push}, 12'h001);
        cmp(vector_pc, 12'h008);
        cmp({11'h000, global_irq_enable}, 12'h000);
        acc(1, 8'hC8, 8'h00);
        acc(1, 8'hC9, 8'h00);
        repeat (40) @(posedge clk);
        #1 cmp({11'h000, global_irq_enable}, 12'h001);
        acc(1, 8'hCA, 8'h01);
        @(posedge clk) port1_pins <= 7'h02;
        repeat (20) @(posedge clk);
        #1 cmp({11'h000, osc_stop}, 12'h001);
        @(posedge clk) port0_pins <= 8'h01;
        wait_run;
        cmp({11'h000, core_halt}, 12'h000);
        acc(0, 8'hCA, 8'h00);
        acc(0, 8'hC8, 8'h01);
        acc(1, 8'hCA, 8'h04);
        acc(1, 8'hCA, 8'h06);
        pulse_ta;
        #1 cmp({11'h000, core_halt}, 12'h000);
        cmp({11'h000, slow_mode}, 12'h001);
        acc(0, 8'hCA, 8'h04);
        acc(1, 8'hCA, 8'h02);
        @(posedge clk) port1_pins <= 7'h03;
        wait_run;
        cmp({11'h000, core_halt | slow_mode}, 12'h000);
        acc(1, 8'hC8, 8'h00);
        @(posedge clk) port0_pins <= 8'h00;
        repeat (8) @(posedge clk);
        acc(0, 8'hC8, 8'h01);
        conclude;
    end
endmodule
